// file: hdl/msg_port_pkg.sv
// Purpose: Shared constants and types for the message coprocessor local port
// Assumes: 32-bit host data path, word-indexed register offsets
// Notes: Register index times four gives the byte address
package msg_port_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int LANES = DATA_W / 8;
  localparam int COUNT_W = 16;
  localparam int DUTY_W = 8;
  // Register indices on the low word address lines
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_TX_DATA = 4'h2;
  localparam logic [ADDR_W-1:0] REG_RX_DATA = 4'h3;
  localparam logic [ADDR_W-1:0] REG_DMA_COUNT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_THROTTLE = 4'h5;
  localparam logic [ADDR_W-1:0] REG_TX_LAST = 4'h6;
  // Status register bits
  localparam int ST_TX_DONE = 0;
  localparam int ST_RX_DONE = 1;
  localparam int ST_TX_IE = 2;
  localparam int ST_RX_IE = 3;
  localparam int ST_TX_SPACE = 4;
  localparam int ST_RX_AVAIL = 5;
  localparam int ST_OVERRUN = 6;
  // Control register bits
  localparam int CT_WIDTH_LSB = 0;
  localparam int CT_DMA_DIR = 2;
  localparam logic [1:0] WIDTH_RESET = 2'h3;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  // Idle unit of the sender throttle
  localparam int CLK_PERIOD_NS = 8;
  localparam int IDLE_UNIT_NS = 64;
  localparam int IDLE_UNIT_CYCLES = (IDLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic last;
  } msg_word_t;
  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_IN = 2'b01,
    DMA_OUT = 2'b10
  } dma_state_t;
endpackage

// file: hdl/msg_word_buf.sv
// Purpose: Small valid/ready buffer for message words
// Assumes: Depth is a power of two
// Notes: Full and empty are flops so ready and valid leave straight from registers
`timescale 1ns/1ps
`default_nettype none
module msg_word_buf
  import msg_port_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire msg_word_t in_word,
  input wire logic in_valid,
  output logic in_ready,
  output msg_word_t out_word,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("msg_word_buf: DEPTH must be a power of two of at least 2");
  end
  msg_word_t mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;
  logic [PW:0] next_count;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_word = mem[rd_ptr];
  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_word;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr <= wr_ptr + PW'(push);
      rd_ptr <= rd_ptr + PW'(pop);
      count <= next_count;
      in_ready <= (next_count != (PW+1)'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end
endmodule // msg_word_buf
`default_nettype wire

// file: hdl/msg_throttle.sv
// Purpose: Idle gap timer between outgoing messages
// Assumes: start is a one-cycle pulse at the end of each message
// Notes: Gap is duty units long; duty of zero means no gap
`timescale 1ns/1ps
`default_nettype none
module msg_throttle
  import msg_port_pkg::*;
#(
  parameter int UNIT_CYCLES = IDLE_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [DUTY_W-1:0] duty,
  output logic idle
);
  localparam int CW = DUTY_W + $clog2(UNIT_CYCLES + 1) + 1;
  initial
  begin
    if (UNIT_CYCLES < 1)
      $error("msg_throttle: UNIT_CYCLES must be at least 1");
  end
  logic [CW-1:0] remain;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      remain <= '0;
      idle <= 1'b0;
    end
    else if (start && duty != '0)
    begin
      remain <= CW'(duty * UNIT_CYCLES - 1);
      idle <= 1'b1;
    end
    else if (remain != '0)
      remain <= remain - 1'b1;
    else
      idle <= 1'b0;
  end
  property p_gap_starts;
    @(posedge clk) disable iff (!rst_n)
    start && duty != '0 |=> idle;
  endproperty
  a_gap_starts: assert property (p_gap_starts) else $error("idle gap not held after message"); // RULE13
endmodule // msg_throttle
`default_nettype wire

// file: hdl/msg_local_port.sv
// Purpose: Local processor port of a message passing bus controller
// Assumes: External decode drives reg_select; clk is the local bus clock
// Notes: DMA strobes are recognised by an active acknowledge, not by address
// Notes on behaviour
// RULE1: Outside decoder classifies accesses from upper address, cycle type and lock.
// RULE2: Low word address lines arrive undecoded, timed by the host.
// RULE3: Byte enables and data lines connect straight through, no logic between.
// RULE4: Port serves hosts of 8, 16, 24 or 32 bit data width.
// RULE5: Without DMA, host treats transfer requests as interrupts and block-moves data.
// RULE6: Transmit-complete flag sets when a solicited message was sent.
// RULE7: Receive-complete flag sets when a solicited message was received.
// RULE8: With its enable set, a completion raises the message interrupt.
// RULE9: Inbound request for link-to-local data, outbound request for the reverse.
// RULE10: DMA controller wins the local bus, then acknowledges before moving data.
// RULE11: A DMA request stays high until the whole operation ends.
// RULE12: Acknowledge may gap; data moves only while acknowledge is active.
// RULE13: Receiver hands a duty parameter; sender idles between messages accordingly.
// RULE14: A burst-capable DMA controller is the efficient choice.
// RULE15: Interrupt drops when its flag or its enable is cleared.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module msg_local_port
  import msg_port_pkg::*;
#(
  parameter int BUF_DEPTH = 2,
  parameter int UNIT_CYCLES = IDLE_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_select,
  input wire logic [ADDR_W-1:0] low_word_address,
  input wire logic [LANES-1:0] byte_enable,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [DATA_W-1:0] read_data,
  output logic inbound_xfer_request,
  output logic outbound_xfer_request,
  input wire logic inbound_xfer_ack_n,
  input wire logic outbound_xfer_ack_n,
  output logic message_irq,
  output msg_word_t tx_word,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_sent,
  input wire msg_word_t rx_word,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [DUTY_W-1:0] duty_to_sender,
  input wire logic [DUTY_W-1:0] duty_from_receiver
);
  initial
  begin
    if (DATA_W != 32 || BUF_DEPTH < 2)
      $error("msg_local_port: unsupported data width or buffer depth");
  end
  // True when the access touches the highest lane of the configured host width
  function automatic logic top_lane_hit(input logic [LANES-1:0] be, input logic [1:0] w);
    top_lane_hit = be[w];
  endfunction
  logic solicited_tx_done;
  logic solicited_rx_done;
  logic tx_done_irq_enable;
  logic rx_done_irq_enable;
  logic overrun;
  logic [1:0] host_width;
  logic dma_dir_out;
  logic [COUNT_W-1:0] dma_count;
  dma_state_t dma_state;
  dma_state_t next_dma_state;
  logic [DATA_W-1:0] tx_asm;
  logic [DATA_W-1:0] next_tx_asm;
  msg_word_t push_word;
  logic push_valid;
  logic push_ready;
  msg_word_t txb_word;
  logic txb_valid;
  logic txb_pop;
  msg_word_t rxb_word;
  logic rxb_valid;
  logic rx_pop;
  logic idle;
  logic in_ack;
  logic out_ack;
  logic host_wr;
  logic host_rd;
  logic dma_wr;
  logic dma_rd;
  logic tx_data_wr;
  logic [DATA_W-1:0] status_view;
  // An acknowledge and the matching DMA state qualify a DMA strobe; address is not used
  assign in_ack = ~inbound_xfer_ack_n;
  assign out_ack = ~outbound_xfer_ack_n;
  assign dma_wr = write_strobe & out_ack & (dma_state == DMA_OUT); // RULE12
  assign dma_rd = read_strobe & in_ack & (dma_state == DMA_IN); // RULE12
  assign host_wr = write_strobe & reg_select & ~out_ack;
  assign host_rd = read_strobe & reg_select & ~in_ack;
  assign tx_data_wr = host_wr & (low_word_address == REG_TX_DATA
    || low_word_address == REG_TX_LAST); // RULE2
  // Narrow hosts fill the word lane by lane; the top lane completes it
  always_comb
  begin
    next_tx_asm = tx_asm;
    for (int i = 0; i < LANES; i++)
      if (byte_enable[i])
        next_tx_asm[i*8 +: 8] = write_data[i*8 +: 8]; // RULE4
  end
  assign push_word.data = next_tx_asm; // RULE3
  assign push_word.last = dma_wr ? (dma_count == COUNT_ONE)
    : (low_word_address == REG_TX_LAST);
  assign push_valid = (tx_data_wr | dma_wr) & top_lane_hit(byte_enable, host_width); // RULE4
  assign rx_pop = rxb_valid & (dma_rd
    | (host_rd & low_word_address == REG_RX_DATA & top_lane_hit(byte_enable, host_width)));
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_asm <= '0;
    else if (tx_data_wr | dma_wr)
      tx_asm <= next_tx_asm;
  end
  // Completion flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      solicited_tx_done <= 1'b0;
      solicited_rx_done <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      if (tx_sent)
        solicited_tx_done <= 1'b1; // RULE6
      else if (host_wr && low_word_address == REG_STATUS && write_data[ST_TX_DONE])
        solicited_tx_done <= 1'b0; // RULE15
      if (rx_pop && rxb_word.last)
        solicited_rx_done <= 1'b1; // RULE7
      else if (host_wr && low_word_address == REG_STATUS && write_data[ST_RX_DONE])
        solicited_rx_done <= 1'b0; // RULE15
      if (push_valid && !push_ready)
        overrun <= 1'b1;
      else if (host_wr && low_word_address == REG_STATUS && write_data[ST_OVERRUN])
        overrun <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_done_irq_enable <= 1'b0;
      rx_done_irq_enable <= 1'b0;
      host_width <= WIDTH_RESET;
      dma_dir_out <= 1'b0;
      duty_to_sender <= '0;
    end
    else if (host_wr)
    begin
      if (low_word_address == REG_STATUS)
      begin
        tx_done_irq_enable <= write_data[ST_TX_IE];
        rx_done_irq_enable <= write_data[ST_RX_IE];
      end
      if (low_word_address == REG_CONTROL)
      begin
        host_width <= write_data[CT_WIDTH_LSB +: 2];
        dma_dir_out <= write_data[CT_DMA_DIR];
      end
      if (low_word_address == REG_THROTTLE)
        duty_to_sender <= write_data[DUTY_W-1:0]; // RULE13
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      message_irq <= 1'b0;
    else
      message_irq <= (solicited_tx_done & tx_done_irq_enable)
        | (solicited_rx_done & rx_done_irq_enable); // RULE8 RULE15
  end
  // DMA operation: writing a nonzero count starts it, the last word ends it
  always_comb
  begin
    next_dma_state = dma_state;
    unique case (dma_state)
      DMA_IDLE:
        if (host_wr && low_word_address == REG_DMA_COUNT && write_data[COUNT_W-1:0] != '0)
          next_dma_state = dma_dir_out ? DMA_OUT : DMA_IN; // RULE9
      DMA_IN:
        if (dma_rd && rx_pop && dma_count == COUNT_ONE)
          next_dma_state = DMA_IDLE; // RULE11
      DMA_OUT:
        if (dma_wr && push_valid && push_ready && dma_count == COUNT_ONE)
          next_dma_state = DMA_IDLE; // RULE11
      default:
        next_dma_state = DMA_IDLE;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dma_state <= DMA_IDLE;
      dma_count <= '0;
      inbound_xfer_request <= 1'b0;
      outbound_xfer_request <= 1'b0;
    end
    else
    begin
      dma_state <= next_dma_state;
      inbound_xfer_request <= (next_dma_state == DMA_IN); // RULE9 RULE11
      outbound_xfer_request <= (next_dma_state == DMA_OUT); // RULE9 RULE11
      if (dma_state == DMA_IDLE && host_wr && low_word_address == REG_DMA_COUNT)
        dma_count <= write_data[COUNT_W-1:0];
      else if ((dma_rd && rx_pop)
        || (dma_wr && push_valid && push_ready))
        dma_count <= dma_count - COUNT_ONE; // RULE12
    end
  end
  // Transmit buffer; a full buffer drops the word and flags overrun
  msg_word_buf #(.DEPTH(BUF_DEPTH)) u_tx_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_word(push_word),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_word(txb_word),
    .out_valid(txb_valid),
    .out_ready(txb_pop)
  );
  // Output stage is a flop so the throttle never exposes a word during the gap
  assign txb_pop = txb_valid & ~idle & (~tx_valid | (tx_ready & ~tx_word.last)); // RULE13
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_valid <= 1'b0;
      tx_word <= '0;
    end
    else if (txb_pop)
    begin
      tx_valid <= 1'b1;
      tx_word <= txb_word;
    end
    else if (tx_ready)
      tx_valid <= 1'b0;
  end
  msg_throttle #(.UNIT_CYCLES(UNIT_CYCLES)) u_throttle (
    .clk(clk),
    .rst_n(rst_n),
    .start(tx_valid & tx_ready & tx_word.last),
    .duty(duty_from_receiver),
    .idle(idle)
  );
  msg_word_buf #(.DEPTH(BUF_DEPTH)) u_rx_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_word(rx_word),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_word(rxb_word),
    .out_valid(rxb_valid),
    .out_ready(rx_pop)
  );
  always_comb
  begin
    status_view = '0;
    status_view[ST_TX_DONE] = solicited_tx_done;
    status_view[ST_RX_DONE] = solicited_rx_done;
    status_view[ST_TX_IE] = tx_done_irq_enable;
    status_view[ST_RX_IE] = rx_done_irq_enable;
    status_view[ST_TX_SPACE] = push_ready;
    status_view[ST_RX_AVAIL] = rxb_valid;
    status_view[ST_OVERRUN] = overrun;
  end
  // Read data stands one cycle; unmapped indices read zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      read_data <= '0;
    else if (dma_rd)
      read_data <= rxb_word.data;
    else if (host_rd)
    begin
      unique case (low_word_address)
        REG_STATUS: read_data <= status_view;
        REG_CONTROL: read_data <= DATA_W'({dma_dir_out, host_width});
        REG_RX_DATA: read_data <= rxb_word.data;
        REG_DMA_COUNT: read_data <= DATA_W'(dma_count);
        REG_THROTTLE: read_data <= DATA_W'(duty_to_sender);
        default: read_data <= '0;
      endcase
    end
    else
      read_data <= '0;
  end
  property p_tx_done_set;
    @(posedge clk) disable iff (!rst_n)
    tx_sent |=> solicited_tx_done;
  endproperty
  a_tx_done_set: assert property (p_tx_done_set) else $error("tx done not set"); // RULE6
  property p_rx_done_set;
    @(posedge clk) disable iff (!rst_n)
    rx_pop && rxb_word.last |=> solicited_rx_done;
  endproperty
  a_rx_done_set: assert property (p_rx_done_set) else $error("rx done not set"); // RULE7
  property p_irq_raise;
    @(posedge clk) disable iff (!rst_n)
    solicited_tx_done && tx_done_irq_enable |=> message_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq missing"); // RULE8
  property p_irq_drop;
    @(posedge clk) disable iff (!rst_n)
    !(solicited_tx_done && tx_done_irq_enable) && !(solicited_rx_done && rx_done_irq_enable)
      |=> !message_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq stuck"); // RULE15
  property p_dir_exclusive;
    @(posedge clk) disable iff (!rst_n)
    !(inbound_xfer_request && outbound_xfer_request);
  endproperty
  a_dir_exclusive: assert property (p_dir_exclusive) else $error("both requests"); // RULE9
  property p_req_held;
    @(posedge clk) disable iff (!rst_n)
    outbound_xfer_request && dma_count > COUNT_ONE |=> outbound_xfer_request;
  endproperty
  a_req_held: assert property (p_req_held) else $error("request dropped early"); // RULE11
  property p_no_ack_no_move;
    @(posedge clk) disable iff (!rst_n)
    dma_state != DMA_IDLE && inbound_xfer_ack_n && outbound_xfer_ack_n |=> $stable(dma_count);
  endproperty
  a_no_ack_no_move: assert property (p_no_ack_no_move) else $error("moved without ack"); // RULE12
  property p_no_send_idle;
    @(posedge clk) disable iff (!rst_n)
    idle && !tx_valid |=> !tx_valid;
  endproperty
  a_no_send_idle: assert property (p_no_send_idle) else $error("sent during gap"); // RULE13
endmodule // msg_local_port
`default_nettype wire

// file: verif/link_far_end.sv
// Purpose: Far end of the message link for the bench
// Assumes: One receive word in flight at a time
// Notes: Idle receive data flips so a stale word never passes as fresh
`timescale 1ns/1ps
`default_nettype none
module link_far_end
  import msg_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire msg_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_sent,
  input wire logic stall,
  output msg_word_t rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic push,
  input wire msg_word_t push_word
);
  msg_word_t got [16];
  int n_got;
  int gap;
  int min_gap;
  logic seen_last;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_ready <= 1'b0;
      tx_sent <= 1'b0;
      n_got <= 0;
      gap <= 0;
      min_gap <= 255;
      seen_last <= 1'b0;
    end
    else
    begin
      tx_ready <= !stall;
      tx_sent <= 1'b0;
      gap <= gap + 1;
      if (tx_valid && tx_ready)
      begin
        got[n_got[3:0]] <= tx_word;
        n_got <= n_got + 1;
        gap <= 0;
        // Gap is only timed from a message end to the next word
        if (seen_last && gap < min_gap)
          min_gap <= gap;
        seen_last <= tx_word.last;
        tx_sent <= tx_word.last;
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_valid <= 1'b0;
      rx_word <= '0;
    end
    else if (rx_valid && rx_ready)
    begin
      rx_valid <= 1'b0;
      rx_word <= ~rx_word;
    end
    else if (push && !rx_valid)
    begin
      rx_valid <= 1'b1;
      rx_word <= push_word;
    end
  end
endmodule // link_far_end
`default_nettype wire

// file: verif/msg_local_port_tb.sv
// Purpose: Self-checking bench for the message coprocessor local port
// Assumes: Throttle unit shortened to one cycle
// Notes: Register and DMA cycles share one pair of strobe tasks
`timescale 1ns/1ps
`default_nettype none
module msg_local_port_tb;
  import msg_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [LANES-1:0] be = 4'hF;
  logic [DATA_W-1:0] wdata = '0;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic in_req;
  logic out_req;
  logic in_ack_n = 1'b1;
  logic out_ack_n = 1'b1;
  logic irq;
  msg_word_t tx_word;
  msg_word_t rx_word;
  msg_word_t push_word = '0;
  logic tx_valid;
  logic tx_ready;
  logic tx_sent;
  logic rx_valid;
  logic rx_ready;
  logic stall = 1'b0;
  logic push = 1'b0;
  logic [DUTY_W-1:0] duty_out;
  int mismatches = 0;
  int samples_checked = 0;
  int nb;
  always #4 clk = ~clk;
  msg_local_port #(.BUF_DEPTH(2), .UNIT_CYCLES(1)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_select(sel), .low_word_address(addr),
    .byte_enable(be), .write_data(wdata), .write_strobe(wstb), .read_strobe(rstb),
    .read_data(rdata), .inbound_xfer_request(in_req), .outbound_xfer_request(out_req),
    .inbound_xfer_ack_n(in_ack_n), .outbound_xfer_ack_n(out_ack_n), .message_irq(irq),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_sent(tx_sent),
    .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .duty_to_sender(duty_out), .duty_from_receiver(8'h04));
  link_far_end i_far (
    .clk(clk), .rst_n(rst_n), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_sent(tx_sent), .stall(stall), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .push(push), .push_word(push_word));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    wstb <= 1'b1;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge clk);
    wstb <= 1'b0;
    be <= 4'hF;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    rstb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rstb <= 1'b0;
    #1;
    chk(rdata & m, exp);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 60 && i_far.n_got < n; i++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
    chk(i_far.n_got, n);
  endtask
  task automatic send_rx(input msg_word_t w);
    @(posedge clk);
    push <= 1'b1;
    push_word <= w;
    @(posedge clk);
    push <= 1'b0;
    for (int i = 0; i < 20 && rx_valid; i++)
      @(posedge clk);
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_STATUS, 32'h10, 32'hFF);
    rd(REG_CONTROL, 32'h3, 32'h7);
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    sel <= 1'b0;
    wr(REG_THROTTLE, 32'h33, 4'hF);
    sel <= 1'b1;
    #1;
    chk(duty_out, 32'h0);
    wr(REG_THROTTLE, 32'h5A, 4'hF);
    #1;
    chk(duty_out, 32'h5A);
    wr(REG_STATUS, 32'h4, 4'hF);
    wr(REG_TX_DATA, 32'h11111111, 4'hF);
    wr(REG_TX_LAST, 32'h22222222, 4'hF);
    wr(REG_TX_LAST, 32'h33333333, 4'hF);
    wait_got(3);
    chk({i_far.got[0].data[30:0], i_far.got[0].last}, 32'h22222222);
    chk(i_far.got[1].data, 32'h22222222);
    chk({31'h0, i_far.got[2].last}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(REG_STATUS, 32'h15, 32'hFF);
    wr(REG_STATUS, 32'h5, 4'hF);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(REG_CONTROL, 32'h1, 4'hF);
    wr(REG_TX_LAST, 32'h0000ABCD, 4'h3);
    wait_got(4);
    chk(i_far.got[3].data[15:0], 32'hABCD);
    wr(REG_CONTROL, 32'h3, 4'hF);
    // Far side stalls so the buffer has to refuse a word
    stall <= 1'b1;
    nb = 4;
    for (int i = 4; i < 8; i++)
      wr(REG_TX_DATA, i, 4'hF);
    rd(REG_STATUS, 32'h40, 32'h50);
    stall <= 1'b0;
    for (int i = 0; i < 20; i++)
      @(posedge clk);
    rd(REG_STATUS, 32'h50, 32'h50);
    chk(i_far.got[4].data, 32'h4);
    chk(i_far.got[5].data, 32'h5);
    nb = i_far.n_got;
    wr(REG_STATUS, 32'h40, 4'hF);
    wr(REG_CONTROL, 32'h7, 4'hF);
    wr(REG_DMA_COUNT, 32'h3, 4'hF);
    #1;
    chk({30'h0, out_req, in_req}, 32'h2);
    wr(4'hF, 32'hDEAD, 4'hF);
    out_ack_n <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      wr(4'hF, 32'hA0 + i, 4'hF);
      out_ack_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, out_req}, i < 2);
      out_ack_n <= 1'b0;
    end
    out_ack_n <= 1'b1;
    wait_got(nb + 3);
    chk(i_far.got[nb[3:0]].data, 32'hA0);
    chk({i_far.got[nb[3:0] + 4'h2].data[7:0], 7'h0, i_far.got[nb[3:0] + 4'h2].last}, 32'hA201);
    wr(REG_CONTROL, 32'h3, 4'hF);
    send_rx('{data: 32'hB0, last: 1'b0});
    send_rx('{data: 32'hB1, last: 1'b1});
    wr(REG_STATUS, 32'h8, 4'hF);
    wr(REG_DMA_COUNT, 32'h2, 4'hF);
    #1;
    chk({29'h0, rx_ready, out_req, in_req}, 32'h1);
    in_ack_n <= 1'b0;
    rd(4'hF, 32'hB0, 32'hFFFFFFFF);
    rd(4'hF, 32'hB1, 32'hFFFFFFFF);
    in_ack_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({30'h0, in_req, irq}, 32'h1);
    rd(REG_STATUS, 32'h1B, 32'h7F);
    wr(REG_STATUS, 32'h0, 4'hF);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(REG_STATUS, 32'h2, 4'hF);
    send_rx('{data: 32'hC0, last: 1'b1});
    rd(REG_RX_DATA, 32'hC0, 32'hFFFFFFFF);
    rd(REG_STATUS, 32'h02, 32'h22);
    chk(i_far.min_gap >= 4, 32'h1);
    tally_and_finish;
  end
endmodule // msg_local_port_tb
`default_nettype wire
